/* design/tkp_cmd_core.sv */
`include "tkp_params.svh"
`default_nettype none
module tkp_cmd_core #(
   parameter int         USER_BLOCKS = 80,
   parameter int         BLOCK_BYTES = 4,
   // Arbitrary value, stands in for the maker code of the tag
   parameter logic [7:0] MFG_CODE    = 8'h5a
) (
   input  wire logic                       mclk,
   input  wire logic                       sys_rst,
   input  wire tkp_pkg::tkp_rx_t           rxIn,
   input  wire logic                       txReady,
   output tkp_pkg::tkp_tx_t                txOut,
   output tkp_pkg::tkp_resp_t              respInfo,
   input  wire logic [63:0]                uid,
   input  wire tkp_pkg::tkp_tag_state_t    tagState,
   input  wire logic [7:0]                 tagAfi,
   input  wire logic                       survEnabled,
   input  wire logic [15:0]                challenge,
   input  wire logic [31:0]                killPassword,
   input  wire logic [31:0]                privPassword,
   input  wire tkp_pkg::tkp_pwd_t          setPwdIn,
   input  wire logic [8*BLOCK_BYTES-1:0]   memData,
   output logic [7:0]                      memAddr,
   output logic                            killed,
   output logic                            privacyOn,
   output logic                            quietReq,
   output logic                            pquietReq
);
   import tkp_pkg::*;

   if (USER_BLOCKS < 1 || USER_BLOCKS > 256 || BLOCK_BYTES < 1 || BLOCK_BYTES > 8) begin : g_chk
      $error("tkp_cmd_core: unsupported block geometry");
   end

   ////////////////////////////////////////////////////////////////////////////
   tkp_state_t  state;
   tkp_phase_t  phase;
   logic [7:0]  flags, cmd, afiRx, mlen, ext, firstBlk, blkCnt, lastBlk, errCode;
   logic [3:0]  idx, uidLeft;
   logic [2:0]  uidPos, byteIdx;
   logic [31:0] pwdBuf;
   logic        uidMiss, maskMiss, fmtErr, crcErr, errFlag, dataOn, qPend, pqPend;
   logic        pwdMatch, exitMatch;
   logic        isInv, isInvRead, isKill, extMode, lenErr, blkErr, afiMiss, survMiss;
   logic        stateOk, silent, errReply, doData, loadOk, nextLast, goFetch;
   logic [6:0]  len;
   logic [4:0]  maskBytes;
   logic [7:0]  lenMax, maskKeep, uidByte, nextByte;
   logic [3:0]  uidBytes, slotVal;
   logic [8:0]  blkEnd;

   assign isInv     = flags[`TKP_FLG_INV];
   assign isKill    = (cmd == `TKP_CMD_KILL);
   assign isInvRead = (cmd == `TKP_CMD_INV_READ);
   assign extMode   = mlen[`TKP_MLEN_EXT];
   assign len       = mlen[6:0];
   assign maskBytes = 5'((8'(len) + 8'h07) >> 3);
   assign uidByte   = uid[8*idx[2:0] +: 8];
   assign loadOk    = !txOut.valid || txReady;

   // Only mask-covered bits of the current mask byte take part in the compare
   always_comb begin
      int left;
      left = int'(len) - 8 * int'(idx);
      if (idx > 4'h7 || left <= 0) begin
         maskKeep = 8'h00;
      end else if (left >= 8) begin
         maskKeep = 8'hff;
      end else begin
         maskKeep = 8'((9'h001 << left) - 9'h001);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request parser and reply sequencing
   always_ff @(posedge mclk) begin : p_parse
      if (sys_rst) begin
         state <= ST_IDLE;
         flags <= 8'h00;
         cmd <= 8'h00;
         afiRx <= 8'h00;
         mlen <= 8'h00;
         ext <= 8'h00;
         firstBlk <= 8'h00;
         blkCnt <= 8'h00;
         idx <= 4'h0;
         pwdBuf <= 32'h0000_0000;
         uidMiss <= 1'b0;
         maskMiss <= 1'b0;
         fmtErr <= 1'b0;
         crcErr <= 1'b0;
      end else if (state == ST_EXEC) begin
         state <= silent ? ST_IDLE : ST_REPLY;
      end else if (state == ST_REPLY) begin
         if (loadOk && nextLast) begin
            state <= ST_IDLE;
         end else if (loadOk && goFetch) begin
            state <= ST_FETCH;
         end
      end else if (state == ST_FETCH) begin
         state <= ST_REPLY;
      end else if (rxIn.eof) begin
         crcErr <= !rxIn.crcOk;
         fmtErr <= fmtErr || (state != ST_TAIL);
         state <= (state == ST_IDLE || state == ST_DROP) ? ST_IDLE : ST_EXEC;
      end else if (rxIn.valid) begin
         idx <= idx + 4'h1;
         case (state)
            ST_IDLE: begin
               flags <= rxIn.data;
               uidMiss <= 1'b0;
               maskMiss <= 1'b0;
               fmtErr <= 1'b0;
               afiRx <= 8'h00;
               mlen <= 8'h00;
               ext <= 8'h00;
               firstBlk <= 8'h00;
               blkCnt <= 8'h00;
               state <= killed ? ST_DROP : ST_CMD;
            end
            ST_CMD: begin
               cmd <= rxIn.data;
               if (!privacyOn && (rxIn.data == `TKP_CMD_KILL || rxIn.data == `TKP_CMD_PRIV
                                  || rxIn.data == `TKP_CMD_INV_READ)) begin
                  state <= ST_MFG;
               end else begin
                  state <= ST_DROP;
               end
            end
            ST_MFG: begin
               idx <= 4'h0;
               if (rxIn.data != MFG_CODE) begin
                  state <= ST_DROP;
               end else if (isInvRead) begin
                  state <= (isInv && flags[`TKP_FLG_AFI]) ? ST_AFI : ST_MLEN;
               end else if (isKill && (isInv || !(flags[`TKP_FLG_ADDR] || flags[`TKP_FLG_SEL]))) begin
                  state <= ST_DROP;
               end else begin
                  state <= (!isInv && flags[`TKP_FLG_ADDR]) ? ST_UID : ST_PWD;
               end
            end
            ST_UID: begin
               uidMiss <= uidMiss || (rxIn.data != uidByte);
               if (idx == 4'h7) begin
                  idx <= 4'h0;
                  state <= ST_PWD;
               end
            end
            ST_AFI: begin
               afiRx <= rxIn.data;
               idx <= 4'h0;
               state <= ST_MLEN;
            end
            ST_MLEN: begin
               mlen <= rxIn.data;
               idx <= 4'h0;
               if (rxIn.data[`TKP_MLEN_EXT]) begin
                  state <= ST_EXT;
               end else begin
                  state <= (rxIn.data[6:0] != 7'h00) ? ST_MASK : ST_FIRST;
               end
            end
            ST_EXT: begin
               ext <= rxIn.data;
               idx <= 4'h0;
               if (len != 7'h00) begin
                  state <= ST_MASK;
               end else begin
                  state <= rxIn.data[`TKP_EXT_SKIP] ? ST_TAIL : ST_FIRST;
               end
            end
            ST_MASK: begin
               maskMiss <= maskMiss || ((rxIn.data ^ uidByte) & maskKeep) != 8'h00;
               if (5'(idx) == maskBytes - 5'h01) begin
                  state <= (extMode && ext[`TKP_EXT_SKIP]) ? ST_TAIL : ST_FIRST;
               end
            end
            ST_FIRST: begin
               firstBlk <= rxIn.data;
               state <= ST_COUNT;
            end
            ST_COUNT: begin
               blkCnt <= rxIn.data;
               state <= ST_TAIL;
            end
            ST_PWD: begin
               pwdBuf[8*idx[1:0] +: 8] <= rxIn.data;
               if (idx == 4'h3) begin
                  state <= ST_TAIL;
               end
            end
            ST_TAIL: begin
               fmtErr <= 1'b1;
            end
            default: begin
               state <= state;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decision taken in the execute cycle
   always_comb begin
      // 60 bits with 16 slots, else 64
      lenMax   = (isInv && !flags[`TKP_FLG_ONESLOT]) ? `TKP_UID_BITS_16 : `TKP_UID_BITS_1;
      lenErr   = 8'(len) > lenMax;
      blkErr   = !(extMode && ext[`TKP_EXT_SKIP]) && int'(firstBlk) >= USER_BLOCKS;
      afiMiss  = isInv && flags[`TKP_FLG_AFI] && afiRx != 8'h00 && afiRx != tagAfi;
      survMiss = extMode && ext[`TKP_EXT_SURV] && !survEnabled;
      if (isInvRead && extMode && ext[`TKP_EXT_QUIET] && ext[`TKP_EXT_PQUIET]) begin
         stateOk = (tagState == TAG_PQUIET);
      end else if (isInv) begin
         stateOk = (tagState == TAG_READY) || (tagState == TAG_SELECTED);
      end else begin
         stateOk = !flags[`TKP_FLG_SEL] || (tagState == TAG_SELECTED);
      end
      silent   = crcErr || uidMiss || !stateOk
                 || (isInvRead && (maskMiss || afiMiss || survMiss))
                 || (isInv && (fmtErr || lenErr || blkErr));
      errReply = fmtErr || (isInvRead ? (lenErr || blkErr) : !pwdMatch);
      if (!isInvRead || !flags[`TKP_FLG_OPT]) begin
         uidBytes = 4'h0;
      end else if (extMode && ext[`TKP_EXT_FULLID]) begin
         uidBytes = `TKP_UID_BYTES;
      end else begin
         uidBytes = 4'((lenMax - 8'(len) + 8'h07) >> 3);
      end
      blkEnd   = 9'(firstBlk) + 9'(blkCnt);
      doData   = isInvRead && !(extMode && ext[`TKP_EXT_SKIP]);
      slotVal  = 4'(uid >> len);
   end

   // Next reply byte; bytes of a word and of the UID go out low byte first
   always_comb begin
      nextByte = 8'h00;
      nextLast = 1'b0;
      goFetch  = 1'b0;
      case (phase)
         PH_HEAD: begin
            nextByte = errFlag ? `TKP_FLG_ERR : 8'h00;
            nextLast = !errFlag && uidLeft == 4'h0 && !dataOn;
            goFetch  = !errFlag && uidLeft == 4'h0 && dataOn;
         end
         PH_ERR: begin
            nextByte = errCode;
            nextLast = 1'b1;
         end
         // real UID bits fill the bytes
         PH_UID: begin
            nextByte = uid[8*uidPos +: 8];
            nextLast = uidLeft == 4'h1 && !dataOn;
            goFetch  = uidLeft == 4'h1 && dataOn;
         end
         default: begin
            nextByte = memData[8*byteIdx +: 8];
            nextLast = int'(byteIdx) == BLOCK_BYTES - 1 && memAddr == lastBlk;
            goFetch  = int'(byteIdx) == BLOCK_BYTES - 1 && memAddr != lastBlk;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reply byte stream
   always_ff @(posedge mclk) begin : p_reply
      if (sys_rst) begin
         txOut <= '0;
         respInfo <= '0;
         phase <= PH_HEAD;
         errFlag <= 1'b0;
         errCode <= 8'h00;
         uidLeft <= 4'h0;
         uidPos <= 3'h0;
         byteIdx <= 3'h0;
         memAddr <= 8'h00;
         lastBlk <= 8'h00;
         dataOn <= 1'b0;
         qPend <= 1'b0;
         pqPend <= 1'b0;
         quietReq <= 1'b0;
         pquietReq <= 1'b0;
      end else begin
         quietReq <= 1'b0;
         pquietReq <= 1'b0;
         if (state == ST_EXEC) begin
            phase <= PH_HEAD;
            byteIdx <= 3'h0;
            errFlag <= errReply;
            errCode <= (isInvRead && !fmtErr) ? `TKP_ERR_BLOCK : `TKP_ERR_GENERIC;
            uidLeft <= errReply ? 4'h0 : uidBytes;
            uidPos <= 3'(4'h8 - uidBytes);
            dataOn <= doData && !errReply;
            memAddr <= firstBlk;
            lastBlk <= (int'(blkEnd) >= USER_BLOCKS) ? 8'(USER_BLOCKS - 1) : blkEnd[7:0];
            qPend <= isInvRead && extMode && ext[`TKP_EXT_QUIET] && !ext[`TKP_EXT_PQUIET];
            pqPend <= isInvRead && extMode && !ext[`TKP_EXT_QUIET] && ext[`TKP_EXT_PQUIET];
            // write-type timing for kill and privacy
            respInfo.writeTiming <= !isInvRead;
            respInfo.slot <= (isInv && !flags[`TKP_FLG_ONESLOT]) ? slotVal : 4'h0;
         end else if (state == ST_REPLY && loadOk) begin
            txOut <= '{valid: 1'b1, last: nextLast, data: nextByte};
            quietReq <= nextLast && qPend;
            pquietReq <= nextLast && pqPend;
            case (phase)
               PH_HEAD: phase <= errFlag ? PH_ERR : (uidLeft != 4'h0 ? PH_UID : PH_DATA);
               PH_UID: begin
                  uidPos <= uidPos + 3'h1;
                  uidLeft <= uidLeft - 4'h1;
                  if (uidLeft == 4'h1) begin
                     phase <= PH_DATA;
                  end
               end
               PH_DATA: begin
                  byteIdx <= goFetch ? 3'h0 : byteIdx + 3'h1;
                  if (goFetch) begin
                     memAddr <= memAddr + 8'h01;
                  end
               end
               default: phase <= phase;
            endcase
         end else if (txOut.valid && txReady) begin
            txOut.valid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Kill and privacy state
   always_ff @(posedge mclk) begin : p_lock
      if (sys_rst) begin
         killed <= 1'b0;
         privacyOn <= 1'b0;
      end else if (state == ST_EXEC && !silent && !errReply && !isInvRead) begin
         killed <= killed || isKill;
         privacyOn <= privacyOn || !isKill;
      end else if (exitMatch) begin
         privacyOn <= 1'b0;
      end
   end

   tkp_pwd_check u_req_pwd (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .valid     (state == ST_TAIL),
      .masked    (pwdBuf),
      .challenge (challenge),
      .reference (isKill ? killPassword : privPassword),
      .match     (pwdMatch)
   );

   tkp_pwd_check u_exit_pwd (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .valid     (setPwdIn.valid),
      .masked    (setPwdIn.masked),
      .challenge (challenge),
      .reference (privPassword),
      .match     (exitMatch)
   );

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_kill_final: assert property (state == ST_EXEC |-> !killed)
      else $error("command executed after kill");
   a_kill_addressed: assert property ($rose(killed) |->
      $past(flags[`TKP_FLG_ADDR] || flags[`TKP_FLG_SEL]) && !$past(isInv))
      else $error("kill accepted without addressing");
   a_kill_unmask: assert property ($rose(killed) |->
      $past(pwdBuf ^ {challenge, challenge}, 2) == $past(killPassword, 2))
      else $error("kill without unmasked password match");
   a_err_header: assert property (state == ST_REPLY && phase == PH_HEAD && errFlag && loadOk
      |=> txOut.valid && txOut.data == `TKP_FLG_ERR && !txOut.last)
      else $error("error header wrong");
   a_priv_enter: assert property ($rose(privacyOn) |->
      $past(cmd) == `TKP_CMD_PRIV && $past(state) == ST_EXEC)
      else $error("privacy entered without command");
   a_priv_exit: assert property ($fell(privacyOn) |-> $past(exitMatch))
      else $error("privacy left without password");
   a_write_timing: assert property (state == ST_REPLY && !isInvRead
      |-> respInfo.writeTiming)
      else $error("kill or privacy reply not write timed");
   a_inv_silent: assert property (state == ST_EXEC && isInv && (fmtErr || lenErr || blkErr)
      |=> state == ST_IDLE ##1 !$rose(txOut.valid))
      else $error("inventory error produced a reply");
   a_block_limit: assert property (state == ST_FETCH |->
      memAddr <= lastBlk && int'(lastBlk) < USER_BLOCKS)
      else $error("block fetch beyond last user block");
   a_addr_slot: assert property (state == ST_EXEC && !isInv |=> respInfo.slot == 4'h0)
      else $error("addressed reply not in first slot");

   c_kill_done: cover property ($rose(killed));
   c_priv_cycle: cover property ($fell(privacyOn));
   c_inv_data: cover property (state == ST_FETCH ##2 txOut.valid && phase == PH_DATA);
   c_inv_uid: cover property (state == ST_REPLY && phase == PH_UID && loadOk);
endmodule : tkp_cmd_core
`default_nettype wire

/* design/tkp_params.svh */
// Command codes, field positions, error codes and UID limits of the tag command core
`ifndef TKP_PARAMS_SVH
`define TKP_PARAMS_SVH
`define TKP_CMD_INV_READ  8'ha0
`define TKP_CMD_KILL      8'hb9
`define TKP_CMD_PRIV      8'hba
`define TKP_FLG_ERR       8'h01
`define TKP_FLG_INV       2
`define TKP_FLG_SEL       4
`define TKP_FLG_AFI       4
`define TKP_FLG_ADDR      5
`define TKP_FLG_ONESLOT   5
`define TKP_FLG_OPT       6
`define TKP_EXT_SURV      0
`define TKP_EXT_FULLID    1
`define TKP_EXT_SKIP      4
`define TKP_EXT_QUIET     5
`define TKP_EXT_PQUIET    6
`define TKP_MLEN_EXT      7
`define TKP_ERR_GENERIC   8'h0f
`define TKP_ERR_BLOCK     8'h10
`define TKP_UID_BITS_1    8'h40
`define TKP_UID_BITS_16   8'h3c
`define TKP_UID_BYTES     4'h8
`endif

/* design/tkp_pkg.sv */
// Types shared by the tag command core, its interrogator model and the testbench
`default_nettype none
package tkp_pkg;
   typedef enum logic [1:0] {
      TAG_READY = 2'h0, TAG_SELECTED = 2'h1, TAG_QUIET = 2'h3, TAG_PQUIET = 2'h2
   } tkp_tag_state_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_CMD = 4'h1, ST_MFG = 4'h3, ST_UID = 4'h2,
      ST_AFI = 4'h6, ST_MLEN = 4'h7, ST_EXT = 4'h5, ST_MASK = 4'h4,
      ST_FIRST = 4'hc, ST_COUNT = 4'hd, ST_PWD = 4'hf, ST_TAIL = 4'he,
      ST_EXEC = 4'ha, ST_REPLY = 4'hb, ST_FETCH = 4'h9, ST_DROP = 4'h8
   } tkp_state_t;
   typedef enum logic [1:0] {PH_HEAD = 2'h0, PH_ERR = 2'h1, PH_UID = 2'h3, PH_DATA = 2'h2} tkp_phase_t;
   typedef struct packed {logic valid; logic eof; logic crcOk; logic [7:0] data;} tkp_rx_t;
   typedef struct packed {logic valid; logic last; logic [7:0] data;} tkp_tx_t;
   typedef struct packed {logic writeTiming; logic [3:0] slot;} tkp_resp_t;
   typedef struct packed {logic valid; logic [31:0] masked;} tkp_pwd_t;
endpackage : tkp_pkg
`default_nettype wire

/* design/tkp_pwd_check.sv */
// Unmasks a challenge-masked password and compares it with a stored one
`default_nettype none
module tkp_pwd_check (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        valid,
   input  wire logic [31:0] masked,
   input  wire logic [15:0] challenge,
   input  wire logic [31:0] reference,
   output logic             match
);
   ////////////////////////////////////////////////////////////////////////////
   // unmask with challenge
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         match <= 1'b0;
      end else begin
         match <= valid && ((masked ^ {challenge, challenge}) == reference);
      end
   end
endmodule : tkp_pwd_check
`default_nettype wire

/* test/tkp_interrogator.sv */
// Interrogator model: sends request frames and collects the reply bytes
`default_nettype none
module tkp_interrogator (
   input  wire logic             mclk,
   output var tkp_pkg::tkp_rx_t  rxIn,
   output var logic              txReady,
   input  wire tkp_pkg::tkp_tx_t txOut
);
   timeunit 1ns;
   timeprecision 1ns;
   import tkp_pkg::*;
   logic       slow = 1'b0;
   logic       done = 1'b0;
   logic [7:0] got[$];
   initial begin
      rxIn = '0;
      txReady = 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   // Slow mode drops txReady every other cycle so the held reply is exercised
   always @(posedge mclk) begin
      txReady <= slow ? ~txReady : 1'b1;
      if (txOut.valid && txReady) begin
         got.push_back(txOut.data);
         done <= txOut.last;
      end
   end
   task automatic sendFrame(input logic [127:0] b, input int n);
      got.delete();
      done = 1'b0;
      for (int k = 0; k < n; k++) begin
         @(posedge mclk) rxIn <= '{1'b1, 1'b0, 1'b0, b[8*k +: 8]};
      end
      @(posedge mclk) rxIn <= '{1'b0, 1'b1, 1'b1, 8'h00};
      @(posedge mclk) rxIn <= '0;
   endtask : sendFrame
endmodule : tkp_interrogator
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench of the tag command core facing an interrogator model
`default_nettype none
`define TKP_CHK(w, e, g) begin totalChecks++; if ((g) !== (e)) begin nFail++; \
   $display("[FAIL] %s exp %h got %h", w, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import tkp_pkg::*;
   typedef struct {logic [127:0] req; int nReq; logic [95:0] rsp; int nRsp;
      tkp_tag_state_t st; logic [1:0] q;} tkp_row_t;
   localparam logic [63:0] UID = 64'h8877665544332211;
   localparam logic [31:0] KPW = 32'hc0ffee01;
   localparam logic [31:0] PPW = 32'hcafe0001;
   logic           mclk, sysRst, txReady, killed, privacyOn, quietReq, pquietReq, tim, survEn;
   logic [1:0]     q;
   tkp_rx_t        rxIn;
   tkp_tx_t        txOut;
   tkp_resp_t      respInfo;
   tkp_pwd_t       setPwd;
   tkp_tag_state_t tagState;
   tkp_row_t       r;
   logic [15:0]    ch;
   logic [31:0]    memData;
   logic [7:0]     memAddr;
   int             nFail = 0, totalChecks = 0, cyc = 0;
   tkp_row_t rows[13] = '{
      '{{32'h0, UID, 24'h5ab920}, 15, 96'h0f01, 2, TAG_READY, 2'b00},
      '{128'h5ab900, 7, 96'h0, 0, TAG_READY, 2'b00},
      '{128'h0102005aa024, 6, 96'h000000030000000200, 9, TAG_READY, 2'b00},
      '{128'h004f6655443322112c5aa064, 12, 96'h0000004f88776600, 8, TAG_READY, 2'b00},
      '{128'h034f005aa024, 6, 96'h0000004f00, 5, TAG_READY, 2'b00},
      '{128'h0102005aa024, 6, 96'h0, 0, TAG_QUIET, 2'b00},
      '{128'h0050005aa024, 6, 96'h0, 0, TAG_READY, 2'b00},
      '{{16'h0001, UID, 32'h405aa020}, 14, 96'h0000000100, 5, TAG_READY, 2'b00},
      '{{16'h0050, UID, 32'h405aa020}, 14, 96'h1001, 2, TAG_READY, 2'b00},
      '{40'h32805aa064, 5, {UID, 8'h00}, 9, TAG_READY, 2'b01},
      '{40'h51805aa024, 5, 96'h00, 1, TAG_READY, 2'b10},
      '{128'h0102003c5aa034, 7, 96'h000000030000000200, 9, TAG_READY, 2'b00},
      '{128'h0102003d5aa034, 7, 96'h0, 0, TAG_READY, 2'b00}};
   tkp_cmd_core dut_u (.mclk(mclk), .sys_rst(sysRst), .rxIn(rxIn), .txReady(txReady),
      .txOut(txOut), .respInfo(respInfo), .uid(UID), .tagState(tagState), .tagAfi(8'h3c),
      .survEnabled(survEn), .challenge(ch), .killPassword(KPW), .privPassword(PPW),
      .setPwdIn(setPwd), .memData(memData), .memAddr(memAddr), .killed(killed),
      .privacyOn(privacyOn), .quietReq(quietReq), .pquietReq(pquietReq));
   tkp_interrogator p_u (.mclk(mclk), .rxIn(rxIn), .txReady(txReady), .txOut(txOut));
   ////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Synchronous block memory, low byte carries the block number
   always @(posedge mclk) memData <= {24'h0, memAddr};
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         nFail++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d failures %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   task automatic runRow(input tkp_row_t x);
      tagState <= x.st;
      p_u.sendFrame(x.req, x.nReq);
      tim = 1'b0;
      q = 2'b00;
      repeat (80) begin
         @(posedge mclk);
         #1;
         if (txOut.valid) tim = respInfo.writeTiming;
         q = q | {pquietReq, quietReq};
         if (p_u.done) break;
      end
      `TKP_CHK("reply length", x.nRsp, p_u.got.size())
      foreach (p_u.got[k]) `TKP_CHK("reply byte", x.rsp[8*k +: 8], p_u.got[k])
      `TKP_CHK("write timing", x.nRsp > 0 && x.req[15:12] == 4'hb, tim)
      `TKP_CHK("quiet pulse", x.q, q)
   endtask : runRow
   initial begin
      sysRst = 1'b1;
      tagState = TAG_READY;
      setPwd = '0;
      survEn = 1'b1;
      ch = 16'h1234;
      repeat (20) @(posedge mclk);
      sysRst <= 1'b0;
      @(posedge mclk);
      #1;
      `TKP_CHK("reset state", 3'b0, {killed, privacyOn, txOut.valid})
      foreach (rows[i]) begin
         p_u.slow <= i[0];
         runRow(rows[i]);
      end
      // 16 slots: UID bytes above mask and slot nibble, slot nibble sits at UID bits 47:44
      runRow('{128'h004f6655443322112c5aa044, 12, 96'h0000004f887700, 7, TAG_READY, 2'b00});
      `TKP_CHK("reply slot", UID[47:44], respInfo.slot)
      // Surveillance filter must silence a tag whose surveillance status is off
      @(posedge mclk) survEn <= 1'b0;
      runRow('{40'h51805aa024, 5, 96'h0, 0, TAG_READY, 2'b00});
      @(posedge mclk) survEn <= 1'b1;
      r = rows[2];
      r.nRsp = 0;
      runRow('{{PPW ^ {2{ch}}, UID, 24'h5aba20}, 15, 96'h00, 1, TAG_READY, 2'b00});
      `TKP_CHK("privacy on", 1'b1, privacyOn)
      runRow(r);
      @(posedge mclk) setPwd <= '{1'b1, PPW ^ {2{ch}}};
      @(posedge mclk) setPwd <= '0;
      repeat (2) @(posedge mclk);
      #1;
      `TKP_CHK("privacy off", 1'b0, privacyOn)
      runRow(rows[2]);
      ch <= 16'h5555;
      runRow('{{KPW ^ {2{16'h5555}}, UID, 24'h5ab920}, 15, 96'h00, 1, TAG_READY, 2'b00});
      `TKP_CHK("killed", 1'b1, killed)
      runRow(r);
      conclude();
   end
endmodule : testbench
`default_nettype wire
